// ---- ccdr_router.sv ----
// holds the config cycle decoder and router with its apb register window
// assumes an apb master on CLK_IN and far agents that accept one-cycle
// request pulses with registered header fields
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/10ps

// Functional notes
// - link type 1 carries bus on A[23:16]
// - bus zero decodes device number for target
// - device 0 host bridge, 1 pcie bridge
// - bus 0, device 0-2 claimed internally
// - bus 0 other devices: link type 0
// - bus outside bridge range: link type 1
// - bus equals secondary: pcie type 0
// - bus above secondary to subordinate: pcie type 1
// - device on byte6[7:3] or A[15:11]
// - internal target with function above 1 ignored
// - function on byte6[2:0] or A[10:8]
// - register on byte7[7:2] or A[7:2]
module ccdr_router (
	// clock and reset
	input  wire logic        CLK_IN,
	input  wire logic        RESET_N_IN,
	// apb slave
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [7:0]  PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	output logic      [31:0] PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT,
	// common access attributes
	output logic             CFG_WR_OUT,
	output logic      [31:0] CFG_WDATA_OUT,
	// internal function select
	output logic             INT_SEL_OUT,
	output logic      [4:0]  INT_DEV_OUT,
	output logic      [2:0]  INT_FUNC_OUT,
	output logic      [5:0]  INT_REG_OUT,
	// downstream chip link request
	output logic             LINK_REQ_OUT,
	output logic             LINK_TYPE1_OUT,
	output logic      [23:0] LINK_ADDR_OUT,
	// pcie port request
	output logic             PCIE_REQ_OUT,
	output logic             PCIE_TYPE1_OUT,
	output logic      [7:0]  PCIE_BYTE6_OUT,
	output logic      [7:0]  PCIE_BYTE7_OUT,
	output logic      [7:0]  PCIE_BYTE8_OUT
);

	// ************************************************************
	// declarations
	// ************************************************************
	logic [31:0]          cfg_addr_q;  // stored config address bits
	logic [7:0]           sec_bus_q;   // bridge secondary bus
	logic [7:0]           sub_bus_q;   // bridge subordinate bus
	ccdr_pkg::ccdr_route_t route_q;    // last route taken
	ccdr_pkg::ccdr_route_t route_d;    // route of the current access
	logic                 access_w;    // apb access phase
	logic                 issue_w;     // data access issues a cycle
	logic                 mapped_w;    // address hits a register
	logic [7:0]           bus_w;       // decoded bus number
	logic [4:0]           dev_w;       // decoded device number
	logic [2:0]           func_w;      // decoded function number
	logic [5:0]           reg_w;       // decoded register number
	logic [31:0]          rdata_d;     // read mux

	// ************************************************************
	// apb handshake and field split
	// ************************************************************
	// zero wait states: every access phase completes at once
	assign PREADY_OUT = 1'b1;
	assign access_w   = PSEL_IN & PENABLE_IN;
	assign issue_w    = access_w & (PADDR_IN == ccdr_pkg::CFG_DATA_OFS);
	assign mapped_w   = (PADDR_IN == ccdr_pkg::CFG_ADDR_OFS) |
	                    (PADDR_IN == ccdr_pkg::CFG_DATA_OFS) |
	                    (PADDR_IN == ccdr_pkg::SEC_BUS_OFS)  |
	                    (PADDR_IN == ccdr_pkg::SUB_BUS_OFS)  |
	                    (PADDR_IN == ccdr_pkg::STATUS_OFS);
	assign PSLVERR_OUT = access_w & ~mapped_w;
	assign bus_w  = cfg_addr_q[ccdr_pkg::BUS_MSB:ccdr_pkg::BUS_LSB];
	assign dev_w  = cfg_addr_q[ccdr_pkg::DEV_MSB:ccdr_pkg::DEV_LSB];
	assign func_w = cfg_addr_q[ccdr_pkg::FUNC_MSB:ccdr_pkg::FUNC_LSB];
	assign reg_w  = cfg_addr_q[ccdr_pkg::REG_MSB:ccdr_pkg::REG_LSB];

	// ************************************************************
	// register writes
	// ************************************************************
	// config address keeps bits 23:2, the rest stays zero
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			cfg_addr_q <= ccdr_pkg::CFG_ADDR_RST;
		end else if (access_w & PWRITE_IN &
		             (PADDR_IN == ccdr_pkg::CFG_ADDR_OFS)) begin
			cfg_addr_q <= PWDATA_IN & ccdr_pkg::CFG_ADDR_MASK;
		end
	end

	// bridge bus range, steering the route decode
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			sec_bus_q <= ccdr_pkg::BUS_RST;
			sub_bus_q <= ccdr_pkg::BUS_RST;
		end else if (access_w & PWRITE_IN) begin
			if (PADDR_IN == ccdr_pkg::SEC_BUS_OFS) begin
				sec_bus_q <= PWDATA_IN[7:0];
			end
			if (PADDR_IN == ccdr_pkg::SUB_BUS_OFS) begin
				sub_bus_q <= PWDATA_IN[7:0];
			end
		end
	end

	// ************************************************************
	// read data
	// ************************************************************
	// read mux; the data port and holes read as zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		case (PADDR_IN)
			ccdr_pkg::CFG_ADDR_OFS: begin
				rdata_d = cfg_addr_q;
			end
			ccdr_pkg::SEC_BUS_OFS: begin
				rdata_d = {24'h00_0000, sec_bus_q};
			end
			ccdr_pkg::SUB_BUS_OFS: begin
				rdata_d = {24'h00_0000, sub_bus_q};
			end
			ccdr_pkg::STATUS_OFS: begin
				rdata_d = {29'h0000_0000, route_q};
			end
			default: begin
				rdata_d = 32'h0000_0000;
			end
		endcase
	end

	// read data registered in the setup cycle, valid in the access phase
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			PRDATA_OUT <= 32'h0000_0000;
		end else if (PSEL_IN & ~PENABLE_IN & ~PWRITE_IN) begin
			PRDATA_OUT <= rdata_d;
		end
	end

	// ************************************************************
	// route decode
	// ************************************************************
	// picks the target of the access from bus, device and bridge range
	always_comb begin
		route_d = ccdr_pkg::RT_NONE;
		if (bus_w == ccdr_pkg::BUS_ZERO) begin
			// device number picks the agent on the root bus
			if (dev_w <= ccdr_pkg::DEV_LAST_INT) begin
				// host bridge and pcie bridge live here
				if (func_w <= ccdr_pkg::FUNC_LAST) begin
					route_d = ccdr_pkg::RT_INT;
				end else begin
					route_d = ccdr_pkg::RT_IGN;
				end
			end else begin
				route_d = ccdr_pkg::RT_LINK0;
			end
		end else if (bus_w == sec_bus_q) begin
			route_d = ccdr_pkg::RT_PCIE0;
		end else if ((bus_w > sec_bus_q) && (bus_w <= sub_bus_q)) begin
			route_d = ccdr_pkg::RT_PCIE1;
		end else begin
			route_d = ccdr_pkg::RT_LINK1;
		end
	end

	// last route taken, updated at each data access
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			route_q <= ccdr_pkg::RT_NONE;
		end else if (issue_w) begin
			route_q <= route_d;
		end
	end

	// ************************************************************
	// request pulses
	// ************************************************************
	// one-cycle strobes toward the selected target
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			INT_SEL_OUT  <= 1'b0;
			LINK_REQ_OUT <= 1'b0;
			PCIE_REQ_OUT <= 1'b0;
		end else begin
			INT_SEL_OUT  <= issue_w & (route_d == ccdr_pkg::RT_INT);
			LINK_REQ_OUT <= issue_w & ((route_d == ccdr_pkg::RT_LINK0) |
			                           (route_d == ccdr_pkg::RT_LINK1));
			PCIE_REQ_OUT <= issue_w & ((route_d == ccdr_pkg::RT_PCIE0) |
			                           (route_d == ccdr_pkg::RT_PCIE1));
		end
	end

	// ************************************************************
	// request fields
	// ************************************************************
	// header and address fields, held until the next data access
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			CFG_WR_OUT     <= 1'b0;
			CFG_WDATA_OUT  <= 32'h0000_0000;
			INT_DEV_OUT    <= 5'h00;
			INT_FUNC_OUT   <= 3'h0;
			INT_REG_OUT    <= 6'h00;
			LINK_TYPE1_OUT <= 1'b0;
			LINK_ADDR_OUT  <= 24'h00_0000;
			PCIE_TYPE1_OUT <= 1'b0;
			PCIE_BYTE6_OUT <= 8'h00;
			PCIE_BYTE7_OUT <= 8'h00;
			PCIE_BYTE8_OUT <= 8'h00;
		end else if (issue_w) begin
			CFG_WR_OUT     <= PWRITE_IN;
			CFG_WDATA_OUT  <= PWDATA_IN;
			INT_DEV_OUT    <= dev_w;
			INT_FUNC_OUT   <= func_w;
			INT_REG_OUT    <= reg_w;
			LINK_TYPE1_OUT <= (route_d == ccdr_pkg::RT_LINK1);
			// bus only on type 1 cycles, zero on type 0
			LINK_ADDR_OUT[23:16] <= (route_d == ccdr_pkg::RT_LINK1) ?
			                        bus_w : 8'h00;
			LINK_ADDR_OUT[15:11] <= dev_w;
			LINK_ADDR_OUT[10:8]  <= func_w;
			LINK_ADDR_OUT[7:2]   <= reg_w;
			LINK_ADDR_OUT[1:0]   <= 2'h0;
			PCIE_TYPE1_OUT <= (route_d == ccdr_pkg::RT_PCIE1);
			PCIE_BYTE6_OUT <= {dev_w, func_w};
			PCIE_BYTE7_OUT <= {reg_w, 2'h0};
			PCIE_BYTE8_OUT <= bus_w;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RESET_N_IN);

	// a data access toward a given bus class
	sequence s_issue_bus0;
		issue_w && (bus_w == ccdr_pkg::BUS_ZERO);
	endsequence
	sequence s_issue_far;
		issue_w && (bus_w != ccdr_pkg::BUS_ZERO);
	endsequence

	a_link_bus_field: assert property (
		s_issue_far ##0 (bus_w != sec_bus_q) &&
		!((bus_w > sec_bus_q) && (bus_w <= sub_bus_q)) |=>
		LINK_REQ_OUT && LINK_TYPE1_OUT &&
		(LINK_ADDR_OUT[23:16] == $past(bus_w)))
		else $error("link type 1 bus field wrong");

	a_root_dev_decode: assert property (
		s_issue_bus0 |=> (INT_SEL_OUT || LINK_REQ_OUT ||
		(route_q == ccdr_pkg::RT_IGN)) && !PCIE_REQ_OUT)
		else $error("root bus access left the root bus");

	a_bridge_devs: assert property (
		s_issue_bus0 ##0 ((dev_w == ccdr_pkg::DEV_HOST) ||
		(dev_w == ccdr_pkg::DEV_PCIE)) && (func_w == 3'h0) |=>
		INT_SEL_OUT && (INT_DEV_OUT == $past(dev_w)))
		else $error("bridge device not answered");

	a_internal_claim: assert property (
		s_issue_bus0 ##0 (dev_w <= ccdr_pkg::DEV_LAST_INT) |=>
		!LINK_REQ_OUT && !PCIE_REQ_OUT)
		else $error("internal access was forwarded");

	a_link_type0: assert property (
		s_issue_bus0 ##0 (dev_w > ccdr_pkg::DEV_LAST_INT) |=>
		LINK_REQ_OUT && !LINK_TYPE1_OUT &&
		(LINK_ADDR_OUT[23:16] == 8'h00) ##1 !LINK_REQ_OUT)
		else $error("link type 0 not issued once");

	a_pcie_type0: assert property (
		s_issue_far ##0 (bus_w == sec_bus_q) |=>
		PCIE_REQ_OUT && !PCIE_TYPE1_OUT && !LINK_REQ_OUT)
		else $error("pcie type 0 not issued");

	a_pcie_type1: assert property (
		s_issue_far ##0 (bus_w > sec_bus_q) && (bus_w <= sub_bus_q) |=>
		PCIE_REQ_OUT && PCIE_TYPE1_OUT &&
		(PCIE_BYTE8_OUT == $past(bus_w)))
		else $error("pcie type 1 not issued");

	a_bad_func_drop: assert property (
		s_issue_bus0 ##0 (dev_w <= ccdr_pkg::DEV_LAST_INT) &&
		(func_w > ccdr_pkg::FUNC_LAST) |=>
		!INT_SEL_OUT && (route_q == ccdr_pkg::RT_IGN))
		else $error("bad function not dropped");

	a_header_fields: assert property (
		issue_w |=> (PCIE_BYTE6_OUT[7:3] == $past(dev_w)) &&
		(LINK_ADDR_OUT[15:11] == $past(dev_w)) &&
		(INT_DEV_OUT == $past(dev_w)))
		else $error("device field mismatch");

	a_reg_field: assert property (
		issue_w |=> (PCIE_BYTE7_OUT == {$past(reg_w), 2'h0}) &&
		(LINK_ADDR_OUT[7:0] == {$past(reg_w), 2'h0}))
		else $error("register field mismatch");

	a_func_field: assert property (
		issue_w |=> (LINK_ADDR_OUT[10:8] == $past(func_w)) &&
		(PCIE_BYTE6_OUT[2:0] == $past(func_w)))
		else $error("function field mismatch");

	a_single_target: assert property (
		!$onehot0({INT_SEL_OUT, LINK_REQ_OUT, PCIE_REQ_OUT}) |-> 1'b0)
		else $error("more than one target strobed");

	a_range_unsigned: assert property (
		s_issue_far ##0 (bus_w < sec_bus_q) |=>
		LINK_REQ_OUT && LINK_TYPE1_OUT)
		else $error("bus below secondary not on link");

endmodule

// ---- ccdr_pkg.sv ----
// holds the shared constants and route codes of the config cycle router
// assumes a 32-bit apb register window with byte addresses below 0x20
package ccdr_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] CFG_ADDR_OFS = 8'h00; // config cycle address
	localparam logic [7:0] CFG_DATA_OFS = 8'h04; // data access, issues cycle
	localparam logic [7:0] SEC_BUS_OFS  = 8'h08; // secondary bus number
	localparam logic [7:0] SUB_BUS_OFS  = 8'h0C; // subordinate bus number
	localparam logic [7:0] STATUS_OFS   = 8'h10; // last route taken

	// ************************************************************
	// config address field layout
	// ************************************************************
	localparam int BUS_MSB  = 23; // bus number field
	localparam int BUS_LSB  = 16;
	localparam int DEV_MSB  = 15; // device number field
	localparam int DEV_LSB  = 11;
	localparam int FUNC_MSB = 10; // function number field
	localparam int FUNC_LSB = 8;
	localparam int REG_MSB  = 7;  // doubleword register number field
	localparam int REG_LSB  = 2;

	// ************************************************************
	// reset values and fixed numbers
	// ************************************************************
	localparam logic [31:0] CFG_ADDR_RST = 32'h0000_0000;
	localparam logic [7:0]  BUS_RST      = 8'h00;
	localparam logic [7:0]  BUS_ZERO     = 8'h00;  // the root bus
	localparam logic [4:0]  DEV_HOST     = 5'h00;  // host bridge device
	localparam logic [4:0]  DEV_PCIE     = 5'h01;  // pcie bridge device
	localparam logic [4:0]  DEV_LAST_INT = 5'h02;  // highest internal device
	localparam logic [2:0]  FUNC_LAST    = 3'h1;   // highest valid function
	localparam logic [31:0] CFG_ADDR_MASK = 32'h00FF_FFFC; // stored bits

	// ************************************************************
	// route codes, shown in the status register
	// ************************************************************
	typedef enum logic [2:0] {
		RT_NONE  = 3'b000, // nothing issued yet
		RT_INT   = 3'b001, // claimed by an internal function
		RT_IGN   = 3'b010, // internal target, bad function, dropped
		RT_LINK0 = 3'b011, // type 0 on the downstream chip link
		RT_LINK1 = 3'b100, // type 1 on the downstream chip link
		RT_PCIE0 = 3'b101, // type 0 request on the pcie port
		RT_PCIE1 = 3'b110  // type 1 request on the pcie port
	} ccdr_route_t;

endpackage

// ---- ccdr_far_agents.sv ----
// holds a model of the pcie port and downstream chip link agents
// assumes one-cycle request pulses from the router on a shared clock
`timescale 1ns/10ps
module ccdr_far_agents (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       reset_n_in,
	// request pulses from the router
	input  wire logic       link_req_in,
	input  wire logic       pcie_req_in,
	// counts of requests accepted
	output logic      [7:0] link_cnt_out,
	output logic      [7:0] pcie_cnt_out
);
	// ************************************************************
	// agents never stall, so every pulse is accepted and counted
	// ************************************************************
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			link_cnt_out <= 8'h00;
			pcie_cnt_out <= 8'h00;
		end else begin
			link_cnt_out <= link_cnt_out + {7'h00, link_req_in};
			pcie_cnt_out <= pcie_cnt_out + {7'h00, pcie_req_in};
		end
	end
endmodule

// ---- ccdr_router_tb_top.sv ----
// holds the self-checking bench of the config cycle router
// assumes the router and the far agent model are compiled before it
`timescale 1ns/10ps
module ccdr_router_tb_top;
	// ************************************************************
	// signals
	// ************************************************************
	logic        clk, rst_n, psel, penable, pwrite;  // bus master side
	logic [7:0]  paddr, lcnt, pcnt, exp_l, exp_p;     // address, counts
	logic [31:0] pwdata, prdata, rd_q;                // data words
	logic        pready, pslverr, err_q, cwr, isel, lreq, lt1, preq, pt1;
	logic [31:0] cwdata;                              // last write data
	logic [4:0]  idev;                                // field outputs
	logic [2:0]  ifunc;
	logic [5:0]  ireg;
	logic [23:0] laddr;
	logic [7:0]  b6, b7, b8;
	int          error_cnt, comparisons;              // tallies
	ccdr_router i_ccdr_router (.CLK_IN(clk), .RESET_N_IN(rst_n),
		.PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
		.PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .CFG_WR_OUT(cwr),
		.CFG_WDATA_OUT(cwdata), .INT_SEL_OUT(isel), .INT_DEV_OUT(idev),
		.INT_FUNC_OUT(ifunc), .INT_REG_OUT(ireg), .LINK_REQ_OUT(lreq),
		.LINK_TYPE1_OUT(lt1), .LINK_ADDR_OUT(laddr), .PCIE_REQ_OUT(preq),
		.PCIE_TYPE1_OUT(pt1), .PCIE_BYTE6_OUT(b6), .PCIE_BYTE7_OUT(b7),
		.PCIE_BYTE8_OUT(b8));
	ccdr_far_agents i_ccdr_far_agents (.clk_in(clk), .reset_n_in(rst_n),
		.link_req_in(lreq), .pcie_req_in(preq), .link_cnt_out(lcnt),
		.pcie_cnt_out(pcnt));
	// ************************************************************
	// clock, reset and watchdog
	// ************************************************************
	initial clk = 1'b0;
	always #2 clk = ~clk;
	initial begin
		#20000;
		error_cnt++;
		wrap_up();
	end
	// ************************************************************
	// tasks
	// ************************************************************
	// prints the tallies and the verdict, then ends the run
	task automatic wrap_up();
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// compares one value against its expectation
	task automatic chk(input string nm, input logic [39:0] e,
		input logic [39:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one apb transfer; holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) chk("pready", 40'h1, 40'h0);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	// sets the address, issues one data access and checks the route taken
	task automatic cfg(input logic [7:0] bus, input logic [4:0] dev,
		input logic [2:0] fn, input logic [5:0] rg, input logic w,
		input ccdr_pkg::ccdr_route_t rt);
		logic [31:0] ad;
		logic [2:0]  pl;
		ad = {8'h00, bus, dev, fn, rg, 2'b00};
		pl = (rt == ccdr_pkg::RT_INT) ? 3'b100 :
			(rt == ccdr_pkg::RT_LINK0 || rt == ccdr_pkg::RT_LINK1) ? 3'b010 :
			(rt == ccdr_pkg::RT_PCIE0 || rt == ccdr_pkg::RT_PCIE1) ? 3'b001 : 3'b000;
		exp_l = exp_l + {7'h00, pl[1]};
		exp_p = exp_p + {7'h00, pl[0]};
		apb(1'b1, ccdr_pkg::CFG_ADDR_OFS, ad);
		apb(w, ccdr_pkg::CFG_DATA_OFS, ~ad);
		#1;
		chk("pulses", {37'h0, pl}, {37'h0, isel, lreq, preq});
		chk("fields", {26'h0, dev, fn, rg}, {26'h0, idev, ifunc, ireg});
		chk("access", {7'h0, w, ~ad}, {7'h0, cwr, cwdata});
		if (pl[1]) chk("link", {15'h0, rt == ccdr_pkg::RT_LINK1,
			(rt == ccdr_pkg::RT_LINK1) ? bus : 8'h00, dev, fn, rg, 2'b00},
			{15'h0, lt1, laddr});
		if (pl[0]) chk("pcie", {15'h0, rt == ccdr_pkg::RT_PCIE1, bus,
			dev, fn, rg, 2'b00}, {15'h0, pt1, b8, b6, b7});
		apb(1'b0, ccdr_pkg::STATUS_OFS, 32'h0);
		chk("status", {37'h0, rt}, {7'h0, err_q, rd_q});
	endtask
	// ************************************************************
	// tests
	// ************************************************************
	initial begin
		rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 8'h00; pwdata = 32'h0; error_cnt = 0; comparisons = 0;
		exp_l = 8'h00; exp_p = 8'h00;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		// reset values of the register window
		apb(1'b0, ccdr_pkg::CFG_ADDR_OFS, 32'h0);
		chk("addr rst", 40'h0, {8'h0, rd_q});
		apb(1'b0, ccdr_pkg::SEC_BUS_OFS, 32'h0);
		chk("sec rst", 40'h0, {8'h0, rd_q});
		apb(1'b0, ccdr_pkg::SUB_BUS_OFS, 32'h0);
		chk("sub rst", 40'h0, {8'h0, rd_q});
		apb(1'b0, ccdr_pkg::STATUS_OFS, 32'h0);
		chk("status rst", 40'h0, {7'h0, err_q, rd_q});
		// stored bits of the address, unmapped places refused
		apb(1'b1, ccdr_pkg::CFG_ADDR_OFS, 32'hFFFF_FFFF);
		apb(1'b0, ccdr_pkg::CFG_ADDR_OFS, 32'h0);
		chk("addr mask", 40'h00_00FF_FFFC, {8'h0, rd_q});
		apb(1'b1, 8'h18, 32'h1234_5678);
		chk("wr slverr", 40'h1, {39'h0, err_q});
		apb(1'b0, 8'h14, 32'h0);
		chk("rd slverr", 40'h1_0000_0000, {7'h0, err_q, rd_q});
		// bridge range 5..8
		apb(1'b1, ccdr_pkg::SEC_BUS_OFS, 32'hFFFF_FF05);
		apb(1'b1, ccdr_pkg::SUB_BUS_OFS, 32'h0000_0008);
		apb(1'b0, ccdr_pkg::SEC_BUS_OFS, 32'h0);
		chk("sec", 40'h05, {8'h0, rd_q});
		cfg(8'h00, 5'h00, 3'h0, 6'h01, 1'b1, ccdr_pkg::RT_INT);
		cfg(8'h00, 5'h01, 3'h1, 6'h3F, 1'b1, ccdr_pkg::RT_INT);
		cfg(8'h00, 5'h02, 3'h0, 6'h02, 1'b1, ccdr_pkg::RT_INT);
		cfg(8'h00, 5'h02, 3'h2, 6'h03, 1'b1, ccdr_pkg::RT_IGN);
		cfg(8'h00, 5'h00, 3'h7, 6'h04, 1'b1, ccdr_pkg::RT_IGN);
		cfg(8'h00, 5'h03, 3'h5, 6'h2A, 1'b1, ccdr_pkg::RT_LINK0);
		cfg(8'h00, 5'h1F, 3'h7, 6'h15, 1'b0, ccdr_pkg::RT_LINK0);
		cfg(8'h05, 5'h1F, 3'h7, 6'h3F, 1'b1, ccdr_pkg::RT_PCIE0);
		cfg(8'h06, 5'h0A, 3'h3, 6'h11, 1'b1, ccdr_pkg::RT_PCIE1);
		cfg(8'h08, 5'h15, 3'h6, 6'h2A, 1'b1, ccdr_pkg::RT_PCIE1);
		cfg(8'h09, 5'h15, 3'h2, 6'h15, 1'b1, ccdr_pkg::RT_LINK1);
		cfg(8'h04, 5'h0A, 3'h5, 6'h2A, 1'b1, ccdr_pkg::RT_LINK1);
		cfg(8'hFF, 5'h1E, 3'h1, 6'h3E, 1'b0, ccdr_pkg::RT_LINK1);
		// range moved before the address is set, then high range
		apb(1'b1, ccdr_pkg::SEC_BUS_OFS, 32'h09);
		cfg(8'h09, 5'h04, 3'h0, 6'h05, 1'b1, ccdr_pkg::RT_PCIE0);
		apb(1'b1, ccdr_pkg::SEC_BUS_OFS, 32'h80);
		apb(1'b1, ccdr_pkg::SUB_BUS_OFS, 32'hFF);
		cfg(8'hFF, 5'h01, 3'h4, 6'h09, 1'b1, ccdr_pkg::RT_PCIE1);
		cfg(8'h7F, 5'h01, 3'h4, 6'h09, 1'b1, ccdr_pkg::RT_LINK1);
		// far agents saw one request per forwarded access
		chk("link count", {32'h0, exp_l}, {32'h0, lcnt});
		chk("pcie count", {32'h0, exp_p}, {32'h0, pcnt});
		wrap_up();
	end
endmodule
